/* File: hdl/edge_sync.sv */
`timescale 1ns/100ps
module edge_sync (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin,
    input wire logic [1:0] sel,
    output logic level,
    output logic edge_valid,
    output logic edge_opp
);
    import tmr16_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic ev;
        logic op;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;
    logic rise;
    logic fall;

    always_comb begin
        rise = st_r.s2 & ~st_r.s3;
        fall = ~st_r.s2 & st_r.s3;
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        case (sel)
            ESEL_FALL: begin
                st_nxt.ev = fall;
                st_nxt.op = rise;
            end
            ESEL_RISE: begin
                st_nxt.ev = rise;
                st_nxt.op = fall;
            end
            ESEL_BOTH: begin
                st_nxt.ev = rise | fall;
                st_nxt.op = 1'b0;
            end
            default: begin
                st_nxt.ev = 1'b0;
                st_nxt.op = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.s3;
    assign edge_valid = st_r.ev;
    assign edge_opp = st_r.op;
endmodule : edge_sync

/* File: hdl/ev8_if.sv */
`timescale 1ns/100ps
interface ev8_if;
    logic pulse;
    logic clr;
    logic [7:0] cmp;
    logic [7:0] count;
    logic match;
    modport ctl (output pulse, output clr, output cmp, input count, input match);
    modport cnt (input pulse, input clr, input cmp, output count, output match);
endinterface : ev8_if

/* File: hdl/event_counter8.sv */
`timescale 1ns/100ps
module event_counter8 (
    input wire logic mclk,
    input wire logic reset,
    ev8_if.cnt bus
);
    import tmr16_pkg::*;

    typedef struct packed {
        logic [7:0] count;
        logic match;
    } ev8_t;

    ev8_t st_r;
    ev8_t st_nxt;

    // counts gated event pulses; match clears and passes one pulse on
    always_comb begin
        st_nxt = st_r;
        st_nxt.match = 1'b0;
        if (bus.clr) begin
            st_nxt.count = CNT8_RST;
        end else if (bus.pulse) begin
            if (st_r.count == bus.cmp) begin
                st_nxt.count = CNT8_RST;
                st_nxt.match = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.count = st_r.count;
    assign bus.match = st_r.match;
endmodule : event_counter8

/* File: hdl/timer16_capture_cascade_counter.sv */
`timescale 1ns/100ps
module timer16_capture_cascade_counter (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [tmr16_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [tmr16_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic edge_input_a,
    input wire logic edge_input_b,
    input wire logic event_pin,
    input wire logic gate_timer_out,
    output logic event_a_irq,
    output logic event_b_irq,
    output logic prescale_irq,
    output logic irq
);
    import tmr16_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic aw_ok;
        logic [ADDR_W-1:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] op_mode;
        logic cap_en;
        logic [1:0] esel_a;
        logic [1:0] esel_b;
        logic [2:0] psel;
        logic [15:0] reg_a;
        logic [15:0] reg_b;
        logic [15:0] cnt;
        logic [PRESC_W-1:0] pc;
        logic [7:0] cmp8;
        logic cmp8_clr;
        logic [1:0] esel_ev;
        logic gate_en;
        logic [2:0] stat;
        logic [2:0] mask;
        logic ev_a;
        logic ev_b;
        logic ev_p8;
    } tmr_state_t;

    tmr_state_t st_r;
    tmr_state_t st_nxt;

    logic a_edge;
    logic a_opp;
    logic b_edge;
    logic ev_edge;
    logic gate_level;

    ev8_if ev8 ();

    // ****************************************
    // pin synchronisers and the 8-bit counter
    // ****************************************
    edge_sync u_sync_a (
        .mclk(mclk),
        .reset(reset),
        .pin(edge_input_a),
        .sel(st_r.esel_a),
        .level(),
        .edge_valid(a_edge),
        .edge_opp(a_opp)
    );

    edge_sync u_sync_b (
        .mclk(mclk),
        .reset(reset),
        .pin(edge_input_b),
        .sel(st_r.esel_b),
        .level(),
        .edge_valid(b_edge),
        .edge_opp()
    );

    edge_sync u_sync_ev (
        .mclk(mclk),
        .reset(reset),
        .pin(event_pin),
        .sel(st_r.esel_ev),
        .level(),
        .edge_valid(ev_edge),
        .edge_opp()
    );

    edge_sync u_sync_gate (
        .mclk(mclk),
        .reset(reset),
        .pin(gate_timer_out),
        .sel(ESEL_NONE),
        .level(gate_level),
        .edge_valid(),
        .edge_opp()
    );

    event_counter8 u_ev8 (
        .mclk(mclk),
        .reset(reset),
        .bus(ev8.cnt)
    );

    assign ev8.pulse = ev_edge & (~st_r.gate_en | gate_level);
    assign ev8.cmp = st_r.cmp8;
    assign ev8.clr = st_r.cmp8_clr;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic presc_tick(input logic [2:0] sel, input logic [PRESC_W-1:0] pc);
        logic [PRESC_W-1:0] m;
        m = PRESC_W'((1 << (PRESC_STEP * int'(sel))) - 1);
        return (pc & m) == m;
    endfunction : presc_tick

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFF_MODE, OFF_PRESC, OFF_REG_A, OFF_REG_B, OFF_CNT16, OFF_CMP8,
            OFF_EVSEL, OFF_ISW, OFF_CNT8, OFF_STAT, OFF_MASK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : mapped

    function automatic logic [31:0] rd_word(input tmr_state_t s, input logic [7:0] c8,
                                            input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            OFF_MODE: begin
                w[MODE_CAP_BIT] = s.cap_en;
                w[MODE_OP_LSB +: 2] = s.op_mode;
                w[MODE_ESA_LSB +: 2] = s.esel_a;
                w[MODE_ESB_LSB +: 2] = s.esel_b;
            end
            OFF_PRESC: w[2:0] = s.psel;
            OFF_REG_A: w[15:0] = s.reg_a;
            OFF_REG_B: w[15:0] = s.reg_b;
            OFF_CNT16: w[15:0] = s.cnt;
            OFF_CMP8: w[7:0] = s.cmp8;
            OFF_EVSEL: w[1:0] = s.esel_ev;
            OFF_ISW: w[ISW_GATE_BIT] = s.gate_en;
            OFF_CNT8: w[7:0] = c8;
            OFF_STAT: w[2:0] = s.stat;
            OFF_MASK: w[2:0] = s.mask;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : rd_word

    // ****************************************
    // next state
    // ****************************************
    logic tick;
    logic do_wr;
    logic [31:0] wr_w;
    logic cap_a;
    logic cap_b;
    logic [2:0] w1c;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ev_a = 1'b0;
        st_nxt.ev_b = 1'b0;
        st_nxt.ev_p8 = ev8.match;
        st_nxt.cmp8_clr = 1'b0;
        w1c = 3'h0;
        tick = 1'b0;
        cap_a = 1'b0;
        cap_b = 1'b0;

        // write channel: address and data taken in either order
        if (awvalid && awready) begin
            st_nxt.aw_ok = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_nxt.w_ok = 1'b1;
            st_nxt.w_data = wdata;
            st_nxt.w_strb = wstrb;
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        do_wr = st_r.aw_ok & st_r.w_ok & ~st_r.bvalid;
        wr_w = merge(rd_word(st_r, ev8.count, st_r.aw_addr), st_r.w_data, st_r.w_strb);
        if (do_wr) begin
            st_nxt.aw_ok = 1'b0;
            st_nxt.w_ok = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (st_r.aw_addr)
                OFF_MODE: begin
                    st_nxt.cap_en = wr_w[MODE_CAP_BIT];
                    st_nxt.op_mode = wr_w[MODE_OP_LSB +: 2];
                    st_nxt.esel_a = wr_w[MODE_ESA_LSB +: 2];
                    st_nxt.esel_b = wr_w[MODE_ESB_LSB +: 2];
                end
                OFF_PRESC: st_nxt.psel = wr_w[2:0];
                OFF_REG_A: st_nxt.reg_a = wr_w[15:0];
                OFF_REG_B: st_nxt.reg_b = wr_w[15:0];
                OFF_CMP8: begin
                    st_nxt.cmp8 = wr_w[7:0];
                    st_nxt.cmp8_clr = 1'b1;
                end
                OFF_EVSEL: st_nxt.esel_ev = wr_w[1:0];
                OFF_ISW: st_nxt.gate_en = wr_w[ISW_GATE_BIT];
                OFF_STAT: w1c = st_r.w_data[2:0] & {3{st_r.w_strb[0]}};
                OFF_MASK: st_nxt.mask = wr_w[2:0];
                default: st_nxt.bresp = RESP_SLVERR;
            endcase
        end

        // read channel
        if (arvalid && arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_word(st_r, ev8.count, araddr);
            st_nxt.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // count clock
        st_nxt.pc = st_r.pc + PRESC_W'(1);
        if (st_r.psel == PSEL_CASCADE) begin
            tick = ev8.match;
        end else if (st_r.psel != PSEL_EDGE_A) begin
            tick = presc_tick(st_r.psel, st_r.pc);
        end

        // 16-bit counter, compare and capture
        if (st_r.op_mode == OP_STOP) begin
            st_nxt.cnt = CNT16_RST;
        end else if (st_r.psel == PSEL_EDGE_A) begin
            st_nxt.cnt = CNT16_RST;
        end else if (st_r.cap_en && (b_edge || a_opp || a_edge)) begin
            cap_a = b_edge | a_opp;
            cap_b = a_edge;
            if (cap_a) begin
                st_nxt.reg_a = st_r.cnt;
                st_nxt.ev_a = 1'b1;
            end
            if (cap_b) begin
                st_nxt.reg_b = st_r.cnt;
                st_nxt.ev_b = 1'b1;
            end
            if (st_r.op_mode == OP_CLR_EDGE) begin
                st_nxt.cnt = CNT16_RST;
            end
        end else if (st_r.op_mode == OP_CLR_EDGE && a_edge) begin
            st_nxt.cnt = CNT16_RST;
        end else if (tick) begin
            if (!st_r.cap_en && st_r.cnt == st_r.reg_a) begin
                st_nxt.ev_a = 1'b1;
            end
            if (!st_r.cap_en && st_r.cnt == st_r.reg_b) begin
                st_nxt.ev_b = 1'b1;
            end
            if (st_r.op_mode == OP_CLR_MATCH && st_r.cnt == st_r.reg_a) begin
                st_nxt.cnt = CNT16_RST;
                st_nxt.ev_a = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end

        // sticky status: a new event wins over a clear in the same cycle
        st_nxt.stat = (st_r.stat & ~w1c);
        st_nxt.stat[ST_EVA] = st_nxt.stat[ST_EVA] | st_nxt.ev_a;
        st_nxt.stat[ST_EVB] = st_nxt.stat[ST_EVB] | st_nxt.ev_b;
        st_nxt.stat[ST_P8] = st_nxt.stat[ST_P8] | st_nxt.ev_p8;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.cmp8 <= CMP8_RST;
            st_r.cnt <= CNT16_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign awready = ~st_r.aw_ok & ~st_r.bvalid;
    assign wready = ~st_r.w_ok & ~st_r.bvalid;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = ~st_r.rvalid;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign event_a_irq = st_r.ev_a;
    assign event_b_irq = st_r.ev_b;
    assign prescale_irq = st_r.ev_p8;
    assign irq = |(st_r.stat & st_r.mask);
endmodule : timer16_capture_cascade_counter

/* File: hdl/tmr16_pkg.sv */
package tmr16_pkg;
    // ****************************************
    // bus and register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_PRESC = 8'h04;
    localparam logic [7:0] OFF_REG_A = 8'h08;
    localparam logic [7:0] OFF_REG_B = 8'h0C;
    localparam logic [7:0] OFF_CNT16 = 8'h10;
    localparam logic [7:0] OFF_CMP8 = 8'h14;
    localparam logic [7:0] OFF_EVSEL = 8'h18;
    localparam logic [7:0] OFF_ISW = 8'h1C;
    localparam logic [7:0] OFF_CNT8 = 8'h20;
    localparam logic [7:0] OFF_STAT = 8'h24;
    localparam logic [7:0] OFF_MASK = 8'h28;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // field positions
    // ****************************************
    localparam int MODE_CAP_BIT = 0;
    localparam int MODE_OP_LSB = 2;
    localparam int MODE_ESA_LSB = 4;
    localparam int MODE_ESB_LSB = 6;
    localparam int ISW_GATE_BIT = 2;
    localparam int ST_EVA = 0;
    localparam int ST_EVB = 1;
    localparam int ST_P8 = 2;
    // ****************************************
    // encodings and reset values
    // ****************************************
    localparam logic [1:0] OP_STOP = 2'h0;
    localparam logic [1:0] OP_FREE = 2'h1;
    localparam logic [1:0] OP_CLR_EDGE = 2'h2;
    localparam logic [1:0] OP_CLR_MATCH = 2'h3;
    localparam logic [2:0] PSEL_EDGE_A = 3'h6;
    localparam logic [2:0] PSEL_CASCADE = 3'h7;
    localparam logic [1:0] ESEL_FALL = 2'h0;
    localparam logic [1:0] ESEL_RISE = 2'h1;
    localparam logic [1:0] ESEL_BOTH = 2'h2;
    localparam logic [1:0] ESEL_NONE = 2'h3;
    localparam int PRESC_W = 10;
    localparam int PRESC_STEP = 2;
    localparam logic [15:0] CNT16_RST = 16'h0000;
    localparam logic [7:0] CNT8_RST = 8'h00;
    localparam logic [7:0] CMP8_RST = 8'hFF;
endpackage : tmr16_pkg

/* File: sim/pin_model.sv */
`timescale 1ns/100ps
module pin_model (
    input wire logic mclk,
    output logic edge_input_a,
    output logic edge_input_b,
    output logic event_pin,
    output logic gate_timer_out
);
    initial begin
        edge_input_a = 1'b0;
        edge_input_b = 1'b0;
        event_pin = 1'b0;
        gate_timer_out = 1'b0;
    end
    // each level held several clocks so the synchroniser sees every edge
    task automatic tog(input int which);
        @(posedge mclk);
        if (which == 0) edge_input_a <= ~edge_input_a;
        else edge_input_b <= ~edge_input_b;
        repeat (6) @(posedge mclk);
    endtask : tog
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge mclk);
            event_pin <= 1'b1;
            repeat (4) @(posedge mclk);
            event_pin <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask : pulses
    task automatic set_gate(input logic v);
        @(posedge mclk);
        gate_timer_out <= v;
        repeat (5) @(posedge mclk);
    endtask : set_gate
endmodule : pin_model

/* File: sim/tb_timer16_capture_cascade_counter.sv */
`timescale 1ns/100ps
module tb_timer16_capture_cascade_counter;
    import tmr16_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] awaddr;
    logic [ADDR_W-1:0] araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic edge_input_a, edge_input_b, event_pin, gate_timer_out;
    logic event_a_irq, event_b_irq, prescale_irq;
    int cyc = 0;
    int p8_seen = 0;
    int err_count = 0;
    int total_checks = 0;

    timer16_capture_cascade_counter timer16_capture_cascade_counter_i (
        .mclk(mclk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .edge_input_a(edge_input_a), .edge_input_b(edge_input_b), .event_pin(event_pin),
        .gate_timer_out(gate_timer_out), .event_a_irq(event_a_irq),
        .event_b_irq(event_b_irq), .prescale_irq(prescale_irq), .irq(irq)
    );
    pin_model pin_model_i (
        .mclk(mclk), .edge_input_a(edge_input_a), .edge_input_b(edge_input_b),
        .event_pin(event_pin), .gate_timer_out(gate_timer_out)
    );

    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (prescale_irq === 1'b1) p8_seen <= p8_seen + 1;
    end
    // ****
    // helpers
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hF);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        check("bvalid wait", 32'(n < 50), 32'h1);
        bready <= 1'b1;
        @(posedge mclk);
        check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        check("rvalid wait", 32'(n < 50), 32'h1);
        rready <= 1'b1;
        @(posedge mclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(what, d, exp);
        check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    endtask : rchk
    task automatic wait_on(input int sel, output int t);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((sel == 0 ? event_a_irq : event_b_irq) !== 1'b1 && n < 70000);
        check("event wait", 32'(n < 70000), 32'h1);
        t = cyc;
    endtask : wait_on
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rchk(OFF_CNT16, 32'h0, "cnt16 reset");
        wr(OFF_REG_A, 32'h1234);
        wr(OFF_REG_A, 32'hABCD, RESP_OKAY, 4'h1);
        rchk(OFF_REG_A, 32'h12CD, "reg a strobe");
        rchk(OFF_CMP8, 32'hFF, "cmp8 reset");
        rd(8'h40, d, r);
        check("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h1, RESP_SLVERR);
    endtask : t_reset
    task automatic t_compare();
        int ta, tb, ta2;
        wr(OFF_REG_A, 32'd20);
        wr(OFF_REG_B, 32'd40);
        wr(OFF_MASK, 32'h1);
        wr(OFF_PRESC, 32'h0);
        wr(OFF_MODE, 32'h4);
        wait_on(0, ta);
        wait_on(1, tb);
        check("a to b spacing", 32'(tb - ta), 32'd20);
        check("irq set", {31'h0, irq}, 32'h1);
        rchk(OFF_STAT, 32'h3, "status ab");
        wr(OFF_STAT, 32'h3);
        check("irq clear", {31'h0, irq}, 32'h0);
        wait_on(0, ta2);
        check("wrap period", 32'(ta2 - ta), 32'd65536);
    endtask : t_compare
    task automatic t_match_clear();
        int t1, t2;
        wr(OFF_REG_A, 32'd100);
        wr(OFF_MODE, 32'hC);
        wait_on(0, t1);
        wait_on(0, t2);
        check("match clear period", 32'(t2 - t1), 32'd101);
    endtask : t_match_clear
    task automatic t_capture();
        int t1, t2, t3, t4;
        // capture on, clear on edge a, rising edges on both inputs
        // the event pulse comes while the pin is still held, so watch alongside
        wr(OFF_MODE, 32'h59);
        fork
            pin_model_i.tog(0);
            wait_on(1, t1);
        join
        fork
            pin_model_i.tog(0);
            wait_on(0, t2);
        join
        rchk(OFF_REG_A, 32'(t2 - t1 - 1), "cap a opposite");
        fork
            pin_model_i.tog(0);
            wait_on(1, t3);
        join
        rchk(OFF_REG_B, 32'(t3 - t2 - 1), "cap b");
        fork
            pin_model_i.tog(1);
            wait_on(0, t4);
        join
        rchk(OFF_REG_A, 32'(t4 - t3 - 1), "cap a from b");
    endtask : t_capture
    task automatic t_edge_clear();
        int t0, t1;
        // compare use, falling edge on input a restarts the count from zero
        wr(OFF_REG_A, 32'd50);
        wr(OFF_MODE, 32'h8);
        t0 = cyc;
        fork
            pin_model_i.tog(0);
            wait_on(0, t1);
        join
        check("edge clear", 32'(t1 - t0), 32'd57);
    endtask : t_edge_clear
    task automatic t_cascade();
        logic [31:0] base;
        logic [1:0] r;
        int p0;
        wr(OFF_MODE, 32'h4);
        wr(OFF_PRESC, 32'h7); // cascade source, never 110
        wr(OFF_CMP8, 32'hFF);
        wr(OFF_EVSEL, {30'h0, ESEL_RISE});
        wr(OFF_MASK, 32'h0);
        wr(OFF_STAT, 32'h7);
        wr(OFF_ISW, 32'h4);
        pin_model_i.pulses(5);
        rchk(OFF_CNT8, 32'h0, "gated cnt8");
        pin_model_i.set_gate(1'b1);
        rd(OFF_CNT16, base, r);
        p0 = p8_seen;
        pin_model_i.pulses(256);
        repeat (8) @(posedge mclk);
        check("p8 pulses", 32'(p8_seen - p0), 32'h1);
        rchk(OFF_CNT8, 32'h0, "cnt8 wrap");
        rchk(OFF_CNT16, base + 32'h1, "cnt16 cascade");
        check("irq masked", {31'h0, irq}, 32'h0);
        pin_model_i.pulses(3);
        repeat (8) @(posedge mclk);
        rchk(OFF_CNT8, 32'h3, "cnt8 count");
    endtask : t_cascade
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        awaddr <= '0;
        araddr <= '0;
        wdata <= '0;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_compare();
        t_match_clear();
        t_capture();
        t_edge_clear();
        t_cascade();
        summarize();
    end
    initial begin
        repeat (85000) @(posedge mclk);
        err_count++;
        summarize();
    end
endmodule : tb_timer16_capture_cascade_counter

/* File: sim/tmr16_props.sv */
`timescale 1ns/100ps
module tmr16_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic event_a_irq,
    input wire logic event_b_irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ****
    // bus answers and timer events
    // ****
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    wr_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    rd_latency_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("read address taken while busy");
    aw_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    ev_a_pulse_a: assert property (event_a_irq |=> !event_a_irq)
        else $error("event a longer than one cycle");
    ev_b_pulse_a: assert property (event_b_irq |=> !event_b_irq)
        else $error("event b longer than one cycle");
endmodule : tmr16_props
bind timer16_capture_cascade_counter tmr16_props tmr16_props_i (
    .mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .event_a_irq(event_a_irq), .event_b_irq(event_b_irq)
);
